// *** include/mao_pkg.sv ***
// Shared constants and types of the memory access ordering block.
`default_nettype none

package mao_pkg;

    // ==========================================================
    // Widths and limits
    localparam int ADDR_W = 32;
    localparam int OUTST_W = 4;
    localparam logic [OUTST_W-1:0] OUTST_MAX = 4'hf;
    localparam logic [2:0] SPEC_LIMIT_CACHED = 3'h5;
    localparam logic [2:0] SPEC_LIMIT_UNCACHED = 3'h2;
    localparam int PAGE_LSB = 10;
    localparam int REGION_LSB = 27;

    // ==========================================================
    // Access sizes and kinds
    typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD} mao_size_t;
    typedef enum logic [2:0] {ACC_PLAIN, ACC_MULTI, ACC_CACHE_OP, ACC_RESERVE, ACC_COND_STORE} mao_kind_t;

    // True when the operand sits on its natural boundary.
    function automatic logic mao_aligned(input mao_size_t size, input logic [1:0] low);
        unique case (size)
            SZ_BYTE: mao_aligned = 1'b1;
            SZ_HALF: mao_aligned = !low[0];
            default: mao_aligned = (low == 2'h0);
        endcase
    endfunction : mao_aligned

endpackage : mao_pkg

`default_nettype wire

// *** rtl/mao_guard_sel.sv ***
// Selects the guarded and no-execute attributes of an instruction address.
`default_nettype none

module mao_guard_sel
    import mao_pkg::*;
(
    input wire logic instruction_translate_bit_in,
    input wire logic [31:0] storage_guarded_register_in,
    input wire logic tlb_g_in,
    input wire logic tlb_noexec_in,
    input wire logic [mao_pkg::ADDR_W-1:0] addr_in,
    output logic guarded_out,
    output logic noexec_out
);

    // ==========================================================
    // Attribute source
    // Real mode looks up one bit per 128 MB region; virtual mode uses the page entry.
    always_comb
    begin
        if (instruction_translate_bit_in)
        begin
            guarded_out = tlb_g_in;
            noexec_out = tlb_noexec_in;
        end
        else
        begin
            guarded_out = storage_guarded_register_in[addr_in[ADDR_W-1:REGION_LSB]];
            noexec_out = 1'b0;
        end
    end

endmodule : mao_guard_sel

`default_nettype wire

// *** rtl/mao_access_ctrl.sv ***
// Memory access ordering, reservation and speculative fetch control.
`default_nettype none

// Notes on behaviour
// - Bytes, aligned halfwords and aligned words go out as one unsplit operation.
// - Unaligned, multiple, string and cache-op accesses are not marked atomic.
// - Load-and-reserve reads an aligned word, sets a reservation, signals it.
// - Conditional store writes only while a reservation exists.
// - Ordering barrier completes all earlier accesses before any later one.
// - Synchronize waits for earlier accesses and holds later instructions.
// - Synchronize behaves and times exactly like the ordering barrier.
// - No hardware coherency with other masters; software manages it.
// - Data reads never go to memory speculatively.
// - Speculative fetch stops at five cached or two uncached instructions.
// - Register branch target fetch waits for pending register updates.
// - Guarded access waits until it is no longer speculative.
// - Guarded bit from region register in real mode, page entry otherwise.
// - Speculative load hitting the data cache may be served from it.
// - Real mode guarded fetch allowed if cached or sequential within next page.
// - Virtual mode guarded or no-execute uncached fetch raises storage interrupt.
// - Unconditional branch stops sequential fetch and redirects to target.
// - System call and return do not stop sequential fetch.
// - Pending count register write blocks fetch through count branch.
// - During trap execution no speculative fetch through link or count.
// - Uncached guarded fetch waits for all earlier instructions, except real-mode sequential within next page; no prefetch there.
module mao_access_ctrl
    import mao_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_in,
    // Data access request from the pipeline.
    input wire logic dreq_valid_in,
    input wire mao_pkg::mao_kind_t dreq_kind_in,
    input wire logic dreq_store_in,
    input wire mao_pkg::mao_size_t dreq_size_in,
    input wire logic [mao_pkg::ADDR_W-1:0] dreq_addr_in,
    input wire logic dreq_spec_in,
    input wire logic dreq_cached_in,
    input wire logic barrier_in,
    input wire logic sync_in,
    output logic dreq_take_out,
    output logic cache_rd_out,
    output logic align_err_out,
    output logic cond_done_out,
    output logic cond_ok_out,
    output logic barrier_done_out,
    output logic pipe_hold_out,
    // Memory side.
    input wire logic mem_done_in,
    output logic mem_req_out,
    output logic mem_write_out,
    output logic [mao_pkg::ADDR_W-1:0] mem_addr_out,
    output mao_pkg::mao_size_t mem_size_out,
    output logic mem_atomic_out,
    output logic mem_reserve_out,
    // Instruction fetch side.
    input wire logic fetch_valid_in,
    input wire logic [mao_pkg::ADDR_W-1:0] fetch_addr_in,
    input wire logic fetch_spec_in,
    input wire logic fetch_seq_in,
    input wire logic fetch_cached_in,
    input wire logic fetch_cacheable_in,
    input wire logic fetch_regtarget_in,
    input wire logic fetch_via_count_in,
    input wire logic prior_done_in,
    input wire logic count_pending_in,
    input wire logic link_pending_in,
    input wire logic trap_active_in,
    input wire logic branch_resolved_in,
    input wire logic uncond_branch_in,
    input wire logic [mao_pkg::ADDR_W-1:0] branch_target_in,
    input wire logic instruction_translate_bit_in,
    input wire logic [31:0] storage_guarded_register_in,
    input wire logic tlb_g_in,
    input wire logic tlb_noexec_in,
    output logic fetch_grant_out,
    output logic fetch_isi_out,
    output logic fetch_redirect_out,
    output logic [mao_pkg::ADDR_W-1:0] fetch_target_out
);

    // ==========================================================
    // State
    typedef struct packed {
        logic [OUTST_W-1:0] outst;
        logic bar_pend;
        logic resv_valid;
        logic [2:0] spec_cnt;
        logic seq_block;
        logic prev_valid;
        logic [ADDR_W-PAGE_LSB-1:0] prev_page;
        logic take;
        logic cache_rd;
        logic align_err;
        logic cond_done;
        logic cond_ok;
        logic bar_done;
        logic mem_req;
        logic mem_write;
        logic [ADDR_W-1:0] mem_addr;
        mao_size_t mem_size;
        logic mem_atomic;
        logic mem_reserve;
        logic grant;
        logic isi;
        logic redirect;
        logic [ADDR_W-1:0] target;
    } mao_state_t;

    mao_state_t state_reg;
    mao_state_t state_next;
    logic guarded;
    logic noexec;
    logic free;
    logic word_ok;
    logic page_ok;
    logic reg_wait;
    logic spec_ok;
    logic guard_ok;
    logic fetch_go;
    logic isi_go;
    logic issue;
    logic [2:0] limit;
    logic [ADDR_W-PAGE_LSB-1:0] page;

    // ==========================================================
    // Attribute lookup
    mao_guard_sel u_guard (
        .instruction_translate_bit_in(instruction_translate_bit_in),
        .storage_guarded_register_in(storage_guarded_register_in),
        .tlb_g_in(tlb_g_in),
        .tlb_noexec_in(tlb_noexec_in),
        .addr_in(fetch_addr_in),
        .guarded_out(guarded),
        .noexec_out(noexec)
    );

    // ==========================================================
    // Fetch decision terms
    // Each term blocks a fetch for one reason; the grant needs all of them clear.
    always_comb
    begin
        page = fetch_addr_in[ADDR_W-1:PAGE_LSB];
        page_ok = state_reg.prev_valid && ((page == state_reg.prev_page) ||
                  (page == state_reg.prev_page + 1'b1));
        limit = fetch_cacheable_in ? SPEC_LIMIT_CACHED : SPEC_LIMIT_UNCACHED;
        reg_wait = fetch_regtarget_in && (fetch_via_count_in ? count_pending_in : link_pending_in);
        spec_ok = !fetch_spec_in || ((state_reg.spec_cnt < limit) &&
                  !(fetch_regtarget_in && trap_active_in));
        guard_ok = !guarded || fetch_cached_in || (!fetch_spec_in && prior_done_in) ||
                   (!instruction_translate_bit_in && fetch_seq_in && page_ok);
        isi_go = fetch_valid_in && !state_reg.grant && !state_reg.isi && instruction_translate_bit_in &&
                 (guarded || noexec) && !fetch_cached_in;
        fetch_go = fetch_valid_in && !state_reg.grant && !state_reg.isi && !isi_go &&
                   !(state_reg.seq_block && fetch_seq_in) && !reg_wait && spec_ok && guard_ok;
    end

    // ==========================================================
    // Data side terms
    // No new access is taken while a barrier drains or has just finished, or while the counter is full.
    always_comb
    begin
        free = !state_reg.take && !state_reg.bar_pend && !state_reg.bar_done && (state_reg.outst != OUTST_MAX);
        word_ok = dreq_addr_in[1:0] == 2'h0;
        issue = 1'b0;
        if (dreq_valid_in && free && !barrier_in && !sync_in &&
            !(dreq_store_in && dreq_kind_in == ACC_COND_STORE && !state_reg.resv_valid) &&
            !(!dreq_store_in && dreq_cached_in && dreq_kind_in != ACC_RESERVE) &&
            !((dreq_kind_in == ACC_RESERVE || dreq_kind_in == ACC_COND_STORE) && !word_ok))
        begin
            issue = !dreq_spec_in;
        end
    end

    // ==========================================================
    // Next state
    always_comb
    begin
        state_next = state_reg;
        state_next.take = 1'b0;
        state_next.cache_rd = 1'b0;
        state_next.align_err = 1'b0;
        state_next.cond_done = 1'b0;
        state_next.cond_ok = 1'b0;
        state_next.bar_done = 1'b0;
        state_next.mem_req = 1'b0;
        state_next.mem_reserve = 1'b0;
        state_next.grant = fetch_go;
        state_next.isi = isi_go;
        state_next.redirect = 1'b0;

        // Completion counting; no snoop port exists, coherency stays with software.
        if (issue && !mem_done_in)
        begin
            state_next.outst = state_reg.outst + 1'b1;
        end
        else if (!issue && mem_done_in && state_reg.outst != '0)
        begin
            state_next.outst = state_reg.outst - 1'b1;
        end

        // Barrier and synchronize share one drain path and one timing.
        if (state_reg.bar_pend && state_reg.outst == '0)
        begin
            state_next.bar_pend = 1'b0;
            state_next.bar_done = 1'b1;
        end
        // A request still held in the done cycle is the one that just finished, not a new one.
        else if ((barrier_in || sync_in) && !state_reg.bar_pend && !state_reg.take && !state_reg.bar_done)
        begin
            state_next.bar_pend = 1'b1;
        end
        else if (dreq_valid_in && free)
        begin
            if ((dreq_kind_in == ACC_RESERVE || dreq_kind_in == ACC_COND_STORE) && !word_ok)
            begin
                state_next.take = 1'b1;
                state_next.align_err = 1'b1;
            end
            else if (!dreq_store_in && dreq_cached_in && dreq_kind_in != ACC_RESERVE)
            begin
                state_next.take = 1'b1;
                state_next.cache_rd = 1'b1;
            end
            else if (dreq_store_in && dreq_kind_in == ACC_COND_STORE && !dreq_spec_in)
            begin
                state_next.take = 1'b1;
                state_next.cond_done = 1'b1;
                state_next.cond_ok = state_reg.resv_valid;
                state_next.resv_valid = 1'b0;
            end
            else if (issue)
            begin
                state_next.take = 1'b1;
                if (dreq_kind_in == ACC_RESERVE)
                begin
                    state_next.resv_valid = 1'b1;
                    state_next.mem_reserve = 1'b1;
                end
            end
        end

        // Memory request carries its atomic marking.
        if (issue)
        begin
            state_next.mem_req = 1'b1;
            state_next.mem_write = dreq_store_in;
            state_next.mem_addr = dreq_addr_in;
            state_next.mem_size = dreq_size_in;
            state_next.mem_atomic = (dreq_kind_in == ACC_PLAIN || dreq_kind_in == ACC_RESERVE ||
                                     dreq_kind_in == ACC_COND_STORE) &&
                                    mao_aligned(dreq_size_in, dreq_addr_in[1:0]);
        end

        // Speculative fetch window.
        if (branch_resolved_in)
        begin
            state_next.spec_cnt = '0;
        end
        if (fetch_go)
        begin
            state_next.prev_valid = 1'b1;
            state_next.prev_page = page;
            if (fetch_spec_in)
            begin
                state_next.spec_cnt = (branch_resolved_in ? 3'h0 : state_reg.spec_cnt) + 3'h1;
            end
            if (!fetch_seq_in)
            begin
                state_next.seq_block = 1'b0;
            end
        end

        // Only unconditional branches break the sequential stream.
        if (uncond_branch_in)
        begin
            state_next.seq_block = 1'b1;
            state_next.redirect = 1'b1;
            state_next.target = branch_target_in;
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // Outputs
    assign dreq_take_out = state_reg.take;
    assign cache_rd_out = state_reg.cache_rd;
    assign align_err_out = state_reg.align_err;
    assign cond_done_out = state_reg.cond_done;
    assign cond_ok_out = state_reg.cond_ok;
    assign barrier_done_out = state_reg.bar_done;
    assign pipe_hold_out = state_reg.bar_pend;
    assign mem_req_out = state_reg.mem_req;
    assign mem_write_out = state_reg.mem_write;
    assign mem_addr_out = state_reg.mem_addr;
    assign mem_size_out = state_reg.mem_size;
    assign mem_atomic_out = state_reg.mem_atomic;
    assign mem_reserve_out = state_reg.mem_reserve;
    assign fetch_grant_out = state_reg.grant;
    assign fetch_isi_out = state_reg.isi;
    assign fetch_redirect_out = state_reg.redirect;
    assign fetch_target_out = state_reg.target;

    // ==========================================================
    // Checks
    property p_no_spec_load;
        @(posedge clk_in) disable iff (reset_in)
        (dreq_valid_in && dreq_spec_in && !dreq_cached_in) |=> !mem_req_out;
    endproperty
    a_no_spec_load: assert property (p_no_spec_load) else $error("speculative load reached memory");

    property p_atomic;
        @(posedge clk_in) disable iff (reset_in)
        (mem_req_out && mem_atomic_out) |-> mao_aligned(mem_size_out, mem_addr_out[1:0]);
    endproperty
    a_atomic: assert property (p_atomic) else $error("unaligned access marked atomic");

    property p_reserve;
        @(posedge clk_in) disable iff (reset_in)
        mem_reserve_out |-> (mem_req_out && !mem_write_out && mem_addr_out[1:0] == 2'h0);
    endproperty
    a_reserve: assert property (p_reserve) else $error("reservation without aligned load");

    property p_cond_fail;
        @(posedge clk_in) disable iff (reset_in)
        (cond_done_out && !cond_ok_out) |-> !mem_req_out;
    endproperty
    a_cond_fail: assert property (p_cond_fail) else $error("failed conditional store wrote");

    property p_cond_clear;
        @(posedge clk_in) disable iff (reset_in)
        cond_done_out |-> !state_reg.resv_valid;
    endproperty
    a_cond_clear: assert property (p_cond_clear) else $error("reservation kept after store");

    property p_barrier;
        @(posedge clk_in) disable iff (reset_in)
        (pipe_hold_out && state_reg.outst != '0) |=> (pipe_hold_out && !dreq_take_out && !barrier_done_out);
    endproperty
    a_barrier: assert property (p_barrier) else $error("barrier passed with accesses open");

    property p_sync_done;
        @(posedge clk_in) disable iff (reset_in)
        (pipe_hold_out && state_reg.outst == '0) |=> (barrier_done_out && !pipe_hold_out);
    endproperty
    a_sync_done: assert property (p_sync_done) else $error("drained barrier did not finish");

    property p_spec_limit;
        @(posedge clk_in) disable iff (reset_in)
        state_reg.spec_cnt <= SPEC_LIMIT_CACHED;
    endproperty
    a_spec_limit: assert property (p_spec_limit) else $error("speculative fetch limit exceeded");

    property p_isi;
        @(posedge clk_in) disable iff (reset_in)
        (fetch_valid_in && !fetch_grant_out && !fetch_isi_out && instruction_translate_bit_in &&
         tlb_g_in && !fetch_cached_in) |=> (fetch_isi_out && !fetch_grant_out);
    endproperty
    a_isi: assert property (p_isi) else $error("guarded fetch did not trap");

    property p_redirect;
        @(posedge clk_in) disable iff (reset_in)
        uncond_branch_in |=> (fetch_redirect_out && fetch_target_out == $past(branch_target_in));
    endproperty
    a_redirect: assert property (p_redirect) else $error("branch did not redirect");

    property p_trap;
        @(posedge clk_in) disable iff (reset_in)
        (fetch_spec_in && fetch_regtarget_in && trap_active_in) |=> !fetch_grant_out;
    endproperty
    a_trap: assert property (p_trap) else $error("register target fetched during trap");

    property p_reg_wait;
        @(posedge clk_in) disable iff (reset_in)
        (fetch_regtarget_in && fetch_via_count_in && count_pending_in) |=> !fetch_grant_out;
    endproperty
    a_reg_wait: assert property (p_reg_wait) else $error("count branch fetched early");

endmodule : mao_access_ctrl

`default_nettype wire

// *** tb/mao_mem_model.sv ***
// Memory system model that finishes each transaction after a set latency.
`default_nettype none

module mao_mem_model
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic mem_req_in,
    input wire logic [3:0] lat_in,
    output logic mem_done_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int due_q[$];
    int now_reg;

    // Queue each request and pulse done once its latency has run, one completion per cycle.
    always @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            due_q.delete();
            now_reg <= 0;
            mem_done_out <= 1'b0;
        end
        else
        begin
            now_reg <= now_reg + 1;
            mem_done_out <= 1'b0;
            if (mem_req_in)
                due_q.push_back(now_reg + int'(lat_in));
            if (due_q.size() > 0 && due_q[0] <= now_reg)
            begin
                mem_done_out <= 1'b1;
                void'(due_q.pop_front());
            end
        end
    end
endmodule : mao_mem_model

`default_nettype wire

// *** tb/tb_memory_access_ordering_speculation.sv ***
// Self-checking bench of the memory access ordering block.
`default_nettype none

module tb_memory_access_ordering_speculation;
    timeunit 1ns;
    timeprecision 1ps;
    import mao_pkg::*;

    // ========
    // Signals
    localparam logic [12:0] SP = 13'h1000, SQ = 13'h0800, CH = 13'h0400, CB = 13'h0200, RG = 13'h0100;
    localparam logic [12:0] VC = 13'h0080, PD = 13'h0040, CP = 13'h0020, LP = 13'h0010, TR = 13'h0008;
    localparam logic [12:0] XL = 13'h0004, TG = 13'h0002, NX = 13'h0001;
    logic clk_in, reset_in, dreq_valid_in, dreq_store_in, dreq_spec_in, dreq_cached_in, barrier_in, sync_in;
    logic dreq_take_out, cache_rd_out, align_err_out, cond_done_out, cond_ok_out, barrier_done_out;
    logic pipe_hold_out, mem_done_in, mem_req_out, mem_write_out, mem_atomic_out, mem_reserve_out;
    logic fetch_valid_in, fetch_spec_in, fetch_seq_in, fetch_cached_in, fetch_cacheable_in, fetch_regtarget_in;
    logic fetch_via_count_in, prior_done_in, count_pending_in, link_pending_in, trap_active_in;
    logic branch_resolved_in, uncond_branch_in, instruction_translate_bit_in, tlb_g_in, tlb_noexec_in;
    logic fetch_grant_out, fetch_isi_out, fetch_redirect_out;
    logic [31:0] dreq_addr_in, mem_addr_out, fetch_addr_in, branch_target_in, storage_guarded_register_in;
    logic [31:0] fetch_target_out, a;
    logic [12:0] fflags;
    logic [3:0] lat;
    mao_kind_t dreq_kind_in;
    mao_size_t dreq_size_in, mem_size_out, sz;
    int fail_count = 0, checked = 0, cyc = 0, done_cyc = 0, n_bar, n_syn;

    mao_access_ctrl dut (.*);
    mao_mem_model mem (.clk_in(clk_in), .reset_in(reset_in), .mem_req_in(mem_req_out), .lat_in(lat),
        .mem_done_out(mem_done_in));

    // Fetch qualifiers travel together as one flag word.
    assign {fetch_spec_in, fetch_seq_in, fetch_cached_in, fetch_cacheable_in, fetch_regtarget_in, fetch_via_count_in,
        prior_done_in, count_pending_in, link_pending_in, trap_active_in, instruction_translate_bit_in, tlb_g_in,
        tlb_noexec_in} = fflags;

    // Clock, cycle count and time of the latest memory completion.
    always #4 clk_in = ~clk_in;
    always @(posedge clk_in)
    begin
        cyc <= cyc + 1;
        if (mem_done_in)
            done_cyc <= cyc;
    end

    // ========
    // Helpers
    // Expected atomic marking of a plain access.
    function automatic logic exp_atomic(input mao_size_t s, input logic [1:0] lo);
        if (s == SZ_BYTE)
            return 1'b1;
        if (s == SZ_HALF)
            return !lo[0];
        return lo == 2'h0;
    endfunction : exp_atomic

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run

    // One data request; the answer word is take, req, write, atomic, reserve, cache, cond done, cond ok, align.
    task automatic data_req(input mao_kind_t k, input logic st, input mao_size_t s, input logic [31:0] ad,
        input logic [1:0] sc, input logic [8:0] exp);
        logic [8:0] r;
        r = 9'h000;
        @(posedge clk_in);
        dreq_valid_in <= 1'b1;
        dreq_kind_in <= k;
        dreq_store_in <= st;
        dreq_size_in <= s;
        dreq_addr_in <= ad;
        {dreq_spec_in, dreq_cached_in} <= sc;
        for (int i = 0; i < 8 && r[8] !== 1'b1; i++)
        begin
            @(posedge clk_in);
            #1;
            r = {dreq_take_out, mem_req_out, {mem_write_out, mem_atomic_out, mem_reserve_out} & {3{mem_req_out}},
                cache_rd_out, cond_done_out, cond_ok_out, align_err_out};
        end
        if (mem_req_out === 1'b1)
        begin
            check("mem_addr", ad, mem_addr_out);
            check("mem_size", 32'(s), 32'(mem_size_out));
        end
        check("data_answer", 32'(exp), 32'(r));
        @(posedge clk_in);
        dreq_valid_in <= 1'b0;
    endtask : data_req

    // One fetch request; the answer is grant then storage interrupt.
    task automatic fetch(input logic [31:0] ad, input logic [12:0] f, input logic [1:0] exp);
        logic [1:0] r;
        r = 2'h0;
        @(posedge clk_in);
        fetch_valid_in <= 1'b1;
        fetch_addr_in <= ad;
        fflags <= f;
        for (int i = 0; i < 6 && r == 2'h0; i++)
        begin
            @(posedge clk_in);
            #1;
            r = {fetch_grant_out, fetch_isi_out};
        end
        check("fetch_answer", 32'(exp), 32'(r));
        @(posedge clk_in);
        fetch_valid_in <= 1'b0;
    endtask : fetch

    task automatic pulse_branch(input logic uncond, input logic [31:0] t);
        @(posedge clk_in);
        uncond_branch_in <= uncond;
        branch_resolved_in <= !uncond;
        branch_target_in <= t;
        @(posedge clk_in);
        uncond_branch_in <= 1'b0;
        branch_resolved_in <= 1'b0;
        #1;
    endtask : pulse_branch

    // Ordering barrier or synchronize; returns the cycles spent waiting for done.
    task automatic order_op(input logic s, output int n);
        int t0;
        n = 0;
        @(posedge clk_in);
        t0 = cyc;
        barrier_in <= !s;
        sync_in <= s;
        @(posedge clk_in);
        #1;
        check("pipe_hold", 32'h1, 32'(pipe_hold_out));
        while (barrier_done_out !== 1'b1 && n < 40)
        begin
            @(posedge clk_in);
            #1;
            n++;
        end
        check("barrier_done", 32'h1, 32'(barrier_done_out));
        check("done_after_mem", 32'h1, 32'(done_cyc >= t0));
        @(posedge clk_in);
        barrier_in <= 1'b0;
        sync_in <= 1'b0;
    endtask : order_op

    // ========
    // Main sequence
    initial
    begin
        clk_in = 1'b0;
        reset_in = 1'b1;
        {dreq_valid_in, dreq_store_in, dreq_addr_in, dreq_spec_in, dreq_cached_in, barrier_in, sync_in} = '0;
        {fetch_valid_in, fetch_addr_in, branch_resolved_in, uncond_branch_in, branch_target_in, fflags} = '0;
        dreq_kind_in = ACC_PLAIN;
        dreq_size_in = SZ_BYTE;
        storage_guarded_register_in = 32'h0000_0100;
        lat = 4'h2;
        void'($urandom(51));
        repeat (5) @(posedge clk_in);
        reset_in <= 1'b0;
        for (int i = 0; i < 12; i++)
        begin
            sz = mao_size_t'($urandom_range(2));
            a = $urandom();
            data_req(ACC_PLAIN, a[31], sz, a, 2'h0, {2'h3, a[31], exp_atomic(sz, a[1:0]), 5'h00});
        end
        data_req(ACC_PLAIN, 1'b0, SZ_HALF, 32'h0000_0101, 2'h0, 9'h180);
        data_req(ACC_PLAIN, 1'b1, SZ_WORD, 32'h0000_0102, 2'h0, 9'h1c0);
        data_req(ACC_MULTI, 1'b0, SZ_WORD, 32'h0000_0100, 2'h0, 9'h180);
        data_req(ACC_CACHE_OP, 1'b0, SZ_WORD, 32'h0000_0100, 2'h0, 9'h180);
        data_req(ACC_RESERVE, 1'b0, SZ_WORD, 32'h0000_0202, 2'h0, 9'h101);
        data_req(ACC_RESERVE, 1'b0, SZ_WORD, 32'h0000_0200, 2'h0, 9'h1b0);
        data_req(ACC_COND_STORE, 1'b1, SZ_WORD, 32'h0000_0200, 2'h0, 9'h1e6);
        data_req(ACC_COND_STORE, 1'b1, SZ_WORD, 32'h0000_0200, 2'h0, 9'h104);
        data_req(ACC_PLAIN, 1'b0, SZ_WORD, 32'h0000_0300, 2'h2, 9'h000);
        data_req(ACC_PLAIN, 1'b0, SZ_WORD, 32'h0000_0300, 2'h3, 9'h108);
        @(posedge clk_in);
        lat <= 4'h8;
        data_req(ACC_PLAIN, 1'b1, SZ_WORD, 32'h0000_0400, 2'h0, 9'h1e0);
        order_op(1'b0, n_bar);
        data_req(ACC_PLAIN, 1'b1, SZ_WORD, 32'h0000_0400, 2'h0, 9'h1e0);
        order_op(1'b1, n_syn);
        check("sync_wait", 32'(n_bar), 32'(n_syn));
        pulse_branch(1'b1, 32'h0000_2000);
        check("redirect", 32'h1, 32'(fetch_redirect_out));
        check("target", 32'h0000_2000, fetch_target_out);
        fetch(32'h0000_1004, SQ, 2'h0);
        fetch(32'h0000_2000, 13'h0000, 2'h2);
        fetch(32'h0000_2004, SQ, 2'h2);
        pulse_branch(1'b0, 32'h0);
        for (int i = 0; i < 6; i++)
            fetch(32'h0000_3000 + 32'(4 * i), SP | CH | CB, (i < 5) ? 2'h2 : 2'h0);
        pulse_branch(1'b0, 32'h0);
        for (int i = 0; i < 3; i++)
            fetch(32'h0000_3100 + 32'(4 * i), SP, (i < 2) ? 2'h2 : 2'h0);
        fetch(32'h0000_4000, RG | VC | CP, 2'h0);
        fetch(32'h0000_4000, RG | VC, 2'h2);
        fetch(32'h0000_4000, RG | LP, 2'h0);
        fetch(32'h0000_4000, SP | CB | RG | TR, 2'h0);
        fetch(32'h0000_4000, RG, 2'h2);
        fetch(32'h0000_5000, XL | TG, 2'h1);
        fetch(32'h0000_5000, XL | NX, 2'h1);
        fetch(32'h0000_5000, XL | TG | CH, 2'h2);
        pulse_branch(1'b0, 32'h0);
        fetch(32'h4000_0000, SP, 2'h0);
        fetch(32'h0000_6000, SP | TG, 2'h2);
        fetch(32'h4000_0000, 13'h0000, 2'h0);
        fetch(32'h4000_0000, PD, 2'h2);
        pulse_branch(1'b0, 32'h0);
        fetch(32'h4000_0400, SP | SQ, 2'h2);
        fetch(32'h4000_0c00, SP | SQ, 2'h0);
        complete_run();
    end

    // Watchdog that ends a hung run.
    initial
    begin
        repeat (20000) @(posedge clk_in);
        fail_count++;
        complete_run();
    end
endmodule : tb_memory_access_ordering_speculation

`default_nettype wire
